// ===== inc/pfsel_pkg.sv
// Purpose: Constants for the port-one pin 0/1 function-select block
// Assumes: Wishbone word addressing, byte address is four times the index
// Notes: Indices of the two select registers are kept as printed
package pfsel_pkg;

  // Register indices; byte address = index * 4
  localparam logic [15:0] PFSEL_IDX_P1_0 = 16'ha058;
  localparam logic [15:0] PFSEL_IDX_P1_1 = 16'ha059;
  localparam logic [15:0] PFSEL_IDX_IRQ_STATUS = 16'ha0f0;
  localparam logic [15:0] PFSEL_IDX_IRQ_MASK = 16'ha0f1;

  // Reset values
  localparam logic [7:0] PFSEL_SEL_RESET = 8'h00;
  localparam logic [1:0] PFSEL_IRQ_RESET = 2'h0;

  // Field positions of both select registers
  localparam int PFSEL_B_GPIO = 0;
  localparam int PFSEL_B_IRQ0 = 1;
  localparam int PFSEL_B_IRQ1 = 2;
  localparam int PFSEL_B_SER3 = 3;
  localparam int PFSEL_B_CAP = 4;
  localparam int PFSEL_B_SER2 = 5;
  localparam int PFSEL_B_TOUCH = 7;

  // Writable bits; bit 6 is unused and reads zero
  localparam logic [7:0] PFSEL_SEL_MASK = 8'hbf;

  // Interrupt status / mask bit positions
  localparam int PFSEL_ST_IRQ0 = 0;
  localparam int PFSEL_ST_IRQ1 = 1;

  // Serial receive idles high when no pin is routed
  localparam logic PFSEL_RXD_IDLE = 1'b1;

endpackage : pfsel_pkg

// ===== logic/pfsel_port1_pin_function.sv
// Purpose: Function select for port-one pins 0 and 1 with Wishbone registers
// Assumes: Single clock clk_sys at 25 MHz; peripherals on the same clock
// Notes: Pad inputs are synchronised; every output is registered
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps

module pfsel_port1_pin_function
  import pfsel_pkg::*;
#(
  parameter int ADR_W = 18
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  // Pads: index 0 is pin P1.0, index 1 is pin P1.1
  input wire logic [1:0] pad_in,
  output logic [1:0] pad_out,
  output logic [1:0] pad_oe,
  // General-purpose I/O side
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  output logic [1:0] gpio_in,
  // Enhanced serial ports two and three
  input wire logic ser2_txd,
  input wire logic ser3_txd,
  output logic ser2_rxd,
  output logic ser3_rxd,
  // Capture/compare channels 0 and 1
  input wire logic cap0_out,
  input wire logic cap0_oe,
  input wire logic cap1_out,
  input wire logic cap1_oe,
  output logic cap0_in,
  output logic cap1_in,
  // Touch-key channels 8 and 9
  output logic touch_channel_8_enable,
  output logic touch_channel_9_enable,
  // Shared pin-interrupt requests
  output logic pin_irq_zero,
  output logic pin_irq_one
);

  generate
    if (ADR_W < 18) begin : g_bad_adr
      $error("ADR_W too small for the register map");
    end
  endgenerate

  // True when a byte address matches four times a register index
  function automatic logic idx_hit(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
    idx_hit = (adr[ADR_W-1:2] == (ADR_W-2)'(idx)) && (adr[1:0] == 2'h0);
  endfunction

  // Lane zero carries every field; unused bit 6 is dropped
  function automatic logic [7:0] sel_wdata(input logic [31:0] dat);
    sel_wdata = dat[7:0] & PFSEL_SEL_MASK;
  endfunction

  // Registers
  logic [7:0] pin_p1_0_function_select_r;
  logic [7:0] pin_p1_1_function_select_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic [1:0] pad_meta_r;
  logic [1:0] pad_sync_r;
  logic irq0_prev_r;
  logic irq1_prev_r;

  // Bus decode
  logic req;
  logic wr_go;
  logic hit_p0;
  logic hit_p1;
  logic hit_st;
  logic hit_mk;
  logic [31:0] rd_nxt;

  // Only sel[0] matters: every field sits in the low byte
  assign req = wb_cyc_i && wb_stb_i;
  // Writes land on the edge where the master samples ack
  assign wr_go = ce && req && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign hit_p0 = idx_hit(wb_adr_i, PFSEL_IDX_P1_0);
  assign hit_p1 = idx_hit(wb_adr_i, PFSEL_IDX_P1_1);
  assign hit_st = idx_hit(wb_adr_i, PFSEL_IDX_IRQ_STATUS);
  assign hit_mk = idx_hit(wb_adr_i, PFSEL_IDX_IRQ_MASK);

  // Bit 6 and all upper bits read zero
  // Read mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_p0) begin
      rd_nxt[7:0] = pin_p1_0_function_select_r;
    end else if (hit_p1) begin
      rd_nxt[7:0] = pin_p1_1_function_select_r;
    end else if (hit_st) begin
      rd_nxt[1:0] = irq_status_r;
    end else if (hit_mk) begin
      rd_nxt[1:0] = irq_mask_r;
    end
  end

  // One wait state; unmapped addresses answer with zero data
  // Trade-off: the wait state buys fully registered read data
  // ce low holds ack too; a master waits out the freeze, but a write whose ack is already high while ce is low is dropped
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= rd_nxt;
      end
    end
  end

  // Reset to zero, bit 6 held at zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_p1_0_function_select_r <= PFSEL_SEL_RESET;
    end else if (wr_go && hit_p0) begin
      pin_p1_0_function_select_r <= sel_wdata(wb_dat_i);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_p1_1_function_select_r <= PFSEL_SEL_RESET;
    end else if (wr_go && hit_p1) begin
      pin_p1_1_function_select_r <= sel_wdata(wb_dat_i);
    end
  end

  // Pads come from outside the clock domain
  // A pad pulse shorter than one clock may be missed
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pad_meta_r <= 2'h0;
      pad_sync_r <= 2'h0;
    end else if (ce) begin
      pad_meta_r <= pad_in;
      pad_sync_r <= pad_meta_r;
    end
  end

  // Field views
  logic touch0, ser2_0, cap_0, ser3_0, gpio_0;
  logic touch1, ser2_1, cap_1, ser3_1, gpio_1;
  assign touch0 = pin_p1_0_function_select_r[PFSEL_B_TOUCH];
  assign ser2_0 = pin_p1_0_function_select_r[PFSEL_B_SER2];
  assign cap_0 = pin_p1_0_function_select_r[PFSEL_B_CAP];
  assign ser3_0 = pin_p1_0_function_select_r[PFSEL_B_SER3];
  assign gpio_0 = pin_p1_0_function_select_r[PFSEL_B_GPIO];
  assign touch1 = pin_p1_1_function_select_r[PFSEL_B_TOUCH];
  assign ser2_1 = pin_p1_1_function_select_r[PFSEL_B_SER2];
  assign cap_1 = pin_p1_1_function_select_r[PFSEL_B_CAP];
  assign ser3_1 = pin_p1_1_function_select_r[PFSEL_B_SER3];
  assign gpio_1 = pin_p1_1_function_select_r[PFSEL_B_GPIO];

  // Pin-zero drive: fixed priority when software sets several outputs.
  // Touch sensing wins over all digital drive so the key stays floating.
  logic out0_nxt;
  logic oe0_nxt;
  always_comb begin
    out0_nxt = 1'b0;
    oe0_nxt = 1'b0;
    if (touch0) begin
      out0_nxt = 1'b0;
      oe0_nxt = 1'b0;
    end else if (ser2_0) begin
      out0_nxt = ser2_txd;
      oe0_nxt = 1'b1;
    end else if (ser3_0) begin
      out0_nxt = ser3_txd;
      oe0_nxt = 1'b1;
    end else if (cap_0) begin
      out0_nxt = cap0_out;
      oe0_nxt = cap0_oe;
    end else if (gpio_0) begin
      out0_nxt = gpio_out[0];
      oe0_nxt = gpio_oe[0];
    end
  end

  // Pin-one drive: receive functions never drive the pad
  // A receive select also blocks GPIO drive; only capture drive, which ranks above it, can still fight the pin
  logic out1_nxt;
  logic oe1_nxt;
  always_comb begin
    out1_nxt = 1'b0;
    oe1_nxt = 1'b0;
    if (touch1) begin
      out1_nxt = 1'b0;
      oe1_nxt = 1'b0;
    end else if (cap_1) begin
      out1_nxt = cap1_out;
      oe1_nxt = cap1_oe;
    end else if (gpio_1 && !ser2_1 && !ser3_1) begin
      out1_nxt = gpio_out[1];
      oe1_nxt = gpio_oe[1];
    end
  end

  // Registered drive, so a select write never glitches the pad enable
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pad_out <= 2'h0;
      pad_oe <= 2'h0;
    end else if (ce) begin
      pad_out <= {out1_nxt, out0_nxt};
      pad_oe <= {oe1_nxt, oe0_nxt};
    end
  end

  // Input routing toward the peripherals
  // Unrouted receive inputs idle high, so no false start bit
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ser2_rxd <= PFSEL_RXD_IDLE;
      ser3_rxd <= PFSEL_RXD_IDLE;
      cap0_in <= 1'b0;
      cap1_in <= 1'b0;
      gpio_in <= 2'h0;
    end else if (ce) begin
      ser2_rxd <= ser2_1 ? pad_sync_r[1] : PFSEL_RXD_IDLE;
      ser3_rxd <= ser3_1 ? pad_sync_r[1] : PFSEL_RXD_IDLE;
      cap0_in <= cap_0 && pad_sync_r[0];
      cap1_in <= cap_1 && pad_sync_r[1];
      gpio_in <= {gpio_1 && pad_sync_r[1], gpio_0 && pad_sync_r[0]};
    end
  end

  // Touch channel enables
  // Sensing starts one cycle after the select write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      touch_channel_8_enable <= 1'b0;
      touch_channel_9_enable <= 1'b0;
    end else if (ce) begin
      touch_channel_8_enable <= touch0;
      touch_channel_9_enable <= touch1;
    end
  end

  // Pin-interrupt conditions; a pin may feed both sources at once
  // Level trigger: a condition holds while the synced pin is high
  logic irq0_nxt;
  logic irq1_nxt;
  assign irq0_nxt = (pin_p1_0_function_select_r[PFSEL_B_IRQ0] && pad_sync_r[0]) ||
                    (pin_p1_1_function_select_r[PFSEL_B_IRQ0] && pad_sync_r[1]);
  assign irq1_nxt = (pin_p1_0_function_select_r[PFSEL_B_IRQ1] && pad_sync_r[0]) ||
                    (pin_p1_1_function_select_r[PFSEL_B_IRQ1] && pad_sync_r[1]);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_irq_zero <= 1'b0;
      pin_irq_one <= 1'b0;
      irq0_prev_r <= 1'b0;
      irq1_prev_r <= 1'b0;
    end else if (ce) begin
      pin_irq_zero <= irq0_nxt;
      pin_irq_one <= irq1_nxt;
      irq0_prev_r <= pin_irq_zero;
      irq1_prev_r <= pin_irq_one;
    end
  end

  // Sticky status: rising request sets, write-one clears, set wins
  // Edge-set, so a pin held high raises one event only
  logic [1:0] ev;
  logic [1:0] clr;
  assign ev[PFSEL_ST_IRQ0] = pin_irq_zero && !irq0_prev_r;
  assign ev[PFSEL_ST_IRQ1] = pin_irq_one && !irq1_prev_r;
  assign clr = (wr_go && hit_st) ? wb_dat_i[1:0] : 2'h0;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_status_r <= PFSEL_IRQ_RESET;
    end else if (ce) begin
      irq_status_r <= (irq_status_r & ~clr) | ev;
    end
  end

  // Mask gates only the summary output, never the status
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_mask_r <= PFSEL_IRQ_RESET;
    end else if (wr_go && hit_mk) begin
      irq_mask_r <= wb_dat_i[1:0];
    end
  end

  // Summary output, one cycle behind status and mask
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

endmodule // pfsel_port1_pin_function

// ===== verification/pfsel_pad_model.sv
// Purpose: Board side of the two pads
// Assumes: Chip drive wins over the board
// Notes: An undriven pad toggles, so a stale level never looks valid
`timescale 1ns/10ps
module pfsel_pad_model (
  // Clock
  input wire logic clk_sys,
  // Chip side
  input wire logic [1:0] pad_out,
  input wire logic [1:0] pad_oe,
  // Board side
  input wire logic [1:0] ext_lvl,
  input wire logic [1:0] ext_en,
  // Resolved level
  output logic [1:0] pad_in
);
  logic [1:0] float_r = 2'h1;
  always_ff @(posedge clk_sys) begin
    float_r <= ~float_r;
  end
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_lvl) | (~pad_oe & ~ext_en & float_r);
endmodule // pfsel_pad_model

// ===== verification/pfsel_assertions.sv
// Purpose: Port assertions for the pin function select block
// Assumes: One clock; ce drops only while routed inputs stand idle
// Notes: Bound from the bench top file
`timescale 1ns/10ps
module pfsel_assertions
  import pfsel_pkg::*;
#(
  parameter int ADR_W = 18
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq,
  // Pins and functions
  input wire logic [1:0] pad_in,
  input wire logic [1:0] pad_oe,
  input wire logic [1:0] gpio_in,
  input wire logic ser2_rxd,
  input wire logic cap0_in,
  input wire logic touch_channel_8_enable,
  input wire logic pin_irq_zero,
  input wire logic pin_irq_one
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic wr0;
  assign wr0 = ce && wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
               wb_adr_i == ADR_W'({PFSEL_IDX_P1_0, 2'b00});
  a_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_layout: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0 && !wb_dat_o[6])
    else $error("unused read bits set");
  a_tx2_drive: assert property (wr0 && wb_dat_i[7:0] == 8'h20 |-> ##2 pad_oe[0])
    else $error("serial two transmit not driving");
  a_touch8_copy: assert property (wr0 |-> ##2 touch_channel_8_enable == $past(wb_dat_i[7], 2))
    else $error("touch enable mismatch");
  a_irq0_cause: assert property ($rose(pin_irq_zero) |-> $past(|pad_in, 3))
    else $error("source zero without high pin");
  a_rxd2_source: assert property (!ser2_rxd |-> !$past(pad_in[1], 3))
    else $error("receive low without low pin");
  a_cap0_level: assert property (cap0_in |-> $past(pad_in[0], 3))
    else $error("capture input without high pin");
  a_gpio1_level: assert property (gpio_in[1] |-> $past(pad_in[1], 3))
    else $error("gpio input without high pin");
  cover property (pin_irq_zero && pin_irq_one);
  cover property ($fell(ser2_rxd));
  cover property ($rose(irq));
endmodule // pfsel_assertions

// ===== verification/port1_pin_function_select_test.sv
// Purpose: Self-checking bench for the pin function select block
// Assumes: 25 MHz clock, ce high except in the freeze scenario
// Notes: Bus waits are bounded
`timescale 1ns/10ps
module port1_pin_function_select_test
  import pfsel_pkg::*;
;
  localparam logic [17:0] A0 = 18'h28160, A1 = 18'h28164, AST = 18'h283c0, AMK = 18'h283c4;
  logic clk_sys = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b1;
  logic [17:0] adr = 18'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, irq, s2rx, s3rx, c0in, c1in, t8, t9, iz, io;
  logic [1:0] pin, pout, poe, gin, ext_lvl = 2'h0, gout = 2'h0, goe = 2'h0;
  logic s2tx = 1'b0, s3tx = 1'b0, c0o = 1'b0, c0e = 1'b0, c1o = 1'b0, c1e = 1'b0;
  logic [7:0] codes [4] = '{8'h20, 8'h08, 8'h10, 8'h01};
  logic [3:0] pat = 4'b1010;
  int fails = 0, compares = 0;
  always #20 clk_sys = ~clk_sys;
  pfsel_port1_pin_function #(.ADR_W(18)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
    .pad_in(pin), .pad_out(pout), .pad_oe(poe), .gpio_out(gout), .gpio_oe(goe), .gpio_in(gin),
    .ser2_txd(s2tx), .ser3_txd(s3tx), .ser2_rxd(s2rx), .ser3_rxd(s3rx), .cap0_out(c0o),
    .cap0_oe(c0e), .cap1_out(c1o), .cap1_oe(c1e), .cap0_in(c0in), .cap1_in(c1in),
    .touch_channel_8_enable(t8), .touch_channel_9_enable(t9), .pin_irq_zero(iz), .pin_irq_one(io));
  pfsel_pad_model model (.clk_sys(clk_sys), .pad_out(pout), .pad_oe(poe), .ext_lvl(ext_lvl),
    .ext_en(2'h3), .pad_in(pin));
  task automatic conclude();
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d, input logic s);
    int n;
    n = 0;
    @(posedge clk_sys);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, {4{s}}, 24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 16) begin
      fails++;
      conclude();
    end
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00, 1'b1);
    chk(n, e, q[7:0]);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  initial begin
    wt(16);
    nrst <= 1'b1;
    rd(A0, 8'h00, "sel0_reset");
    rd(A1, 8'h00, "sel1_reset");
    chk("rx_reset", 8'h3, 8'({s2rx, s3rx}));
    chk("oe_reset", 8'h0, 8'(poe));
    bus(1'b1, A0, 8'hff, 1'b1);
    rd(A0, 8'hbf, "sel0_all");
    bus(1'b1, A1, 8'hff, 1'b0);
    rd(A1, 8'h00, "sel1_nolane");
    bus(1'b1, A1, 8'hff, 1'b1);
    rd(A1, 8'hbf, "sel1_all");
    rd(A1 + 18'h2, 8'h00, "unmapped");
    chk("touch", 8'h3, 8'({t8, t9}));
    chk("oe_touch", 8'h0, 8'(poe));
    {c0e, goe} <= 3'b111;
    for (int k = 0; k < 2; k++) begin
      {s2tx, s3tx, c0o, gout[0]} <= pat ^ {4{k[0]}};
      for (int i = 0; i < 4; i++) begin
        bus(1'b1, A0, codes[i], 1'b1);
        wt(4);
        chk("pin0_drive", 8'({1'b1, pat[3-i] ^ k[0]}), 8'({poe[0], pout[0]}));
      end
    end
    c0o <= 1'b1;
    bus(1'b1, A0, 8'h10, 1'b1);
    wt(5);
    chk("cap0_in", 8'h1, 8'(c0in));
    bus(1'b1, A0, 8'h00, 1'b1);
    bus(1'b1, A1, 8'h28, 1'b1);
    wt(5);
    chk("rx_low", 8'h0, 8'({s2rx, s3rx, poe[1]}));
    ext_lvl <= 2'b10;
    bus(1'b1, A1, 8'h10, 1'b1);
    wt(5);
    chk("cap1_in", 8'h7, 8'({c1in, s2rx, s3rx}));
    c1e <= 1'b1;
    wt(3);
    chk("cap1_drive", 8'h2, 8'({poe[1], pout[1]}));
    {c1e, goe} <= 3'b000;
    bus(1'b1, A1, 8'h01, 1'b1);
    wt(5);
    chk("gpio_in", 8'h2, 8'(gin));
    {goe[1], gout[1]} <= 2'b10;
    wt(3);
    chk("gpio1_drive", 8'h2, 8'({poe[1], pout[1]}));
    bus(1'b1, A0, 8'h06, 1'b1);
    bus(1'b1, A1, 8'h02, 1'b1);
    ext_lvl <= 2'b01;
    wt(5);
    chk("irq_both", 8'h3, 8'({iz, io}));
    ext_lvl <= 2'b10;
    wt(5);
    chk("irq_or", 8'h2, 8'({iz, io}));
    rd(AST, 8'h03, "status");
    chk("irq_masked", 8'h0, 8'(irq));
    bus(1'b1, AMK, 8'h01, 1'b1);
    wt(3);
    chk("irq_on", 8'h1, 8'(irq));
    bus(1'b1, AST, 8'h03, 1'b1);
    wt(3);
    chk("irq_clear", 8'h0, 8'(irq));
    rd(AST, 8'h00, "status_clear");
    ce <= 1'b0;
    ext_lvl <= 2'b01;
    wt(6);
    chk("ce_hold", 8'h2, 8'({iz, io}));
    ce <= 1'b1;
    wt(5);
    chk("ce_run", 8'h3, 8'({iz, io}));
    rd(AST, 8'h02, "status_ce");
    nrst <= 1'b0;
    wt(2);
    nrst <= 1'b1;
    rd(A0, 8'h00, "sel0_rst2");
    rd(A1, 8'h00, "sel1_rst2");
    conclude();
  end
endmodule // port1_pin_function_select_test
bind pfsel_port1_pin_function pfsel_assertions #(.ADR_W(ADR_W)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .pad_in(pad_in), .pad_oe(pad_oe),
  .gpio_in(gpio_in), .ser2_rxd(ser2_rxd), .cap0_in(cap0_in),
  .touch_channel_8_enable(touch_channel_8_enable), .pin_irq_zero(pin_irq_zero),
  .pin_irq_one(pin_irq_one));
